// ---- tb/host_model.sv ----
`timescale 1ns/1ps
`default_nettype none
// Host side of the register port: single-byte strobed accesses
module host_model
(
   input  wire logic        clk_sys,
   output logic      [15:0] regAddr,
   output logic             regWrEn,
   output logic      [7:0]  regWrData,
   output logic             regRdEn,
   input  wire logic [7:0]  regRdData
);
   // Idle bus at time zero
   initial
   begin
      regAddr   = 16'h0000;
      regWrEn   = 1'b0;
      regWrData = 8'h00;
      regRdEn   = 1'b0;
   end

   // One-cycle write; address and data scrambled once released
   task automatic wr(input logic [15:0] a, input logic [7:0] d);
      @(posedge clk_sys);
      regAddr   <= a;
      regWrData <= d;
      regWrEn   <= 1'b1;
      @(posedge clk_sys);
      regWrEn   <= 1'b0;
      regAddr   <= ~a;
      regWrData <= ~d;
   endtask : wr

   // One-cycle read; data is taken one cycle after the strobe edge
   task automatic rd(input logic [15:0] a, output logic [7:0] d);
      @(posedge clk_sys);
      regAddr <= a;
      regRdEn <= 1'b1;
      @(posedge clk_sys);
      regRdEn <= 1'b0;
      regAddr <= ~a;
      #1 d = regRdData;
   endtask : rd
endmodule : host_model
`default_nettype wire

// ---- tb/tb_rx_fifo_status_and_loopback.sv ----
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin samples_checked++; if ((a) !== (b)) begin fails++; \
   $display("[ERR] t=%0t got %0h exp %0h", $time, (a), (b)); end end
module tb_rx_fifo_status_and_loopback;
   import rx_fifo_pkg::*;
   logic        clk_sys, rst, regWrEn, regRdEn, transmitOutputMask;
   logic [15:0] regAddr;
   logic [7:0]  regWrData, regRdData, rdv, loopM;
   logic [7:0]  msgWrite, msgRead, rxPinSerial;
   logic [7:0]  receiverSerial, channelSelectedFlag;
   logic [3:0]  txSerial, txPinOut, txPinOe;
   int          fails, samples_checked, lvl, seed;
   int          cnt [8];
   int          sel [8];
   logic [15:0] regA [8] = '{OFS_MUXED_FLAGS, OFS_FULL_FLAGS, OFS_OVER_FLAGS,
      OFS_NONEMPTY, OFS_THR_LEVEL, OFS_LOOPBACK, OFS_RX_CTRL7, 16'h8000};
   logic [7:0]  regE [8] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h10, 8'h00,
      8'h00, 8'h00};
   logic [7:0]  lvTab [4] = '{8'h00, 8'h01, 8'hFF, 8'h10};

   rx_fifo_status_and_loopback dut (.clk_sys(clk_sys), .rst(rst),
      .regAddr(regAddr), .regWrEn(regWrEn), .regWrData(regWrData),
      .regRdEn(regRdEn), .regRdData(regRdData), .msgWrite(msgWrite),
      .msgRead(msgRead), .rxPinSerial(rxPinSerial), .txSerial(txSerial),
      .receiverSerial(receiverSerial),
      .transmitOutputMask(transmitOutputMask), .txPinOut(txPinOut),
      .txPinOe(txPinOe), .channelSelectedFlag(channelSelectedFlag));
   host_model host (.clk_sys(clk_sys), .regAddr(regAddr), .regWrEn(regWrEn),
      .regWrData(regWrData), .regRdEn(regRdEn), .regRdData(regRdData));

   // 25 MHz system clock
   initial
   begin
      clk_sys = 1'b0;
      forever #20 clk_sys = ~clk_sys;
   end

   // Model flag of one channel: 1 nonempty, 2 over level, 3 full
   function automatic logic flagOf(int i, int k);
      case (k)
         1: return cnt[i] > 0;
         2: return cnt[i] > lvl;
         3: return cnt[i] == FIFO_DEPTH;
         default: return 1'b0;
      endcase
   endfunction : flagOf

   // Negative k picks each channel's own select field
   function automatic logic [7:0] flagByte(int k);
      logic [7:0] v;
      for (int i = 0; i < 8; i++) v[i] = flagOf(i, (k < 0) ? sel[i] : k);
      return v;
   endfunction : flagByte

   task automatic stop_test();
      if (fails == 0 && samples_checked > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask : stop_test

   task automatic chkReg(input logic [15:0] a, input logic [7:0] e);
      host.rd(a, rdv);
      `CHK(rdv, e)
   endtask : chkReg

   // Model consumes what was held up to this edge, then new inputs go out
   task automatic step(input logic [7:0] w, r, p, input logic [3:0] t,
                       input logic m);
      logic [7:0] expRx;
      logic [7:0] expTx;
      @(posedge clk_sys);
      for (int i = 0; i < 8; i++)
      begin
         cnt[i] = cnt[i] + int'(msgWrite[i])
                  - int'(msgRead[i] && cnt[i] > 0);
         if (cnt[i] > FIFO_DEPTH) cnt[i] = FIFO_DEPTH;
         expRx[i] = loopM[i] ? txSerial[i / 2] : rxPinSerial[i];
      end
      expTx = transmitOutputMask ? 8'h00 : {4'hF, txSerial};
      msgWrite           <= w;
      msgRead            <= r;
      rxPinSerial        <= p;
      txSerial           <= t;
      transmitOutputMask <= m;
      #1;
      `CHK(channelSelectedFlag, flagByte(-1))
      `CHK(receiverSerial, expRx)
      `CHK({txPinOe, txPinOut}, expTx)
   endtask : step

   // Idle one cycle, then read every status register
   task automatic checkFlags();
      step(8'h00, 8'h00, rxPinSerial, txSerial, transmitOutputMask);
      chkReg(OFS_NONEMPTY, flagByte(1));
      chkReg(OFS_OVER_FLAGS, flagByte(2));
      chkReg(OFS_FULL_FLAGS, flagByte(3));
      chkReg(OFS_MUXED_FLAGS, flagByte(-1));
   endtask : checkFlags

   // Hang guard
   initial
   begin
      #400000;
      fails++;
      stop_test();
   end

   initial
   begin
      rst = 1'b1;
      msgWrite = 8'h00;
      msgRead = 8'h00;
      rxPinSerial = 8'h00;
      txSerial = 4'h0;
      transmitOutputMask = 1'b0;
      loopM = 8'h00;
      lvl = 16;
      foreach (cnt[i]) cnt[i] = 0;
      foreach (sel[i]) sel[i] = 0;
      seed = $urandom(91);
      repeat (20) @(posedge clk_sys);
      rst <= 1'b0;
      // Reset values, unmapped read included
      for (int k = 0; k < 8; k++) chkReg(regA[k], regE[k]);
      host.wr(OFS_FULL_FLAGS, 8'hFF);
      chkReg(OFS_FULL_FLAGS, 8'h00);
      // Each level: fill past full, then drain, all select codes in use
      for (int k = 0; k < 4; k++)
      begin
         host.wr(OFS_THR_LEVEL, lvTab[k]);
         lvl = int'(lvTab[k] & 8'h1F);
         chkReg(OFS_THR_LEVEL, lvTab[k] & 8'h1F);
         for (int i = 0; i < 8; i++)
         begin
            sel[i] = (i + k) % 4;
            host.wr(16'(OFS_RX_CTRL0 + i), 8'(sel[i]));
         end
         repeat (120) step(8'($urandom | $urandom), 8'($urandom & $urandom),
                           8'($urandom), 4'($urandom), 1'($urandom));
         checkFlags();
         repeat (120) step(8'($urandom & $urandom), 8'($urandom | $urandom),
                           8'($urandom), 4'($urandom), 1'($urandom));
         checkFlags();
      end
      // Loopback self-test with the transmit pins masked
      repeat (4)
      begin
         loopM = 8'($urandom);
         host.wr(OFS_LOOPBACK, loopM);
         chkReg(OFS_LOOPBACK, loopM);
         // system holds mask high during self-test
         repeat (20) step(8'h00, 8'h00, 8'($urandom), 4'($urandom), 1'b1);
      end
      loopM = 8'h00;
      host.wr(OFS_LOOPBACK, loopM);
      repeat (10) step(8'h00, 8'h00, 8'($urandom), 4'($urandom), 1'b0);
      stop_test();
   end
endmodule : tb_rx_fifo_status_and_loopback
`default_nettype wire

// ---- verilog/fifo_flag_calc.sv ----
`timescale 1ns/1ps
`default_nettype none
module fifo_flag_calc
(
   fifo_flag_if.calc flags
);
   import rx_fifo_pkg::*;

   localparam logic [CNT_W-1:0] CNT_FULL = CNT_W'(FIFO_DEPTH);

   // Flags are pure functions of the live count, so a host read that
   // drops the count clears them with no extra state to go stale
   for (genvar ch = 0; ch < RX_CHANNELS; ch++)
   begin : g_chan
      assign flags.fifoNonemptyBit[ch] = (flags.count[ch] != '0);
      // strictly above level; fall out of the compare
      assign flags.fifoOverLevelBit[ch] =
         (flags.count[ch] > {1'b0, flags.thrLevel});
      assign flags.fifoFullBit[ch] = (flags.count[ch] == CNT_FULL);

      always_comb
      begin
         case (flags.flagSourceSelect[ch])
            FSEL_NEVER:    flags.channelSelectedFlag[ch] = 1'b0;
            FSEL_NONEMPTY: flags.channelSelectedFlag[ch] =
                              flags.fifoNonemptyBit[ch];
            FSEL_OVER:     flags.channelSelectedFlag[ch] =
                              flags.fifoOverLevelBit[ch];
            FSEL_FULL:     flags.channelSelectedFlag[ch] =
                              flags.fifoFullBit[ch];
            default:       flags.channelSelectedFlag[ch] = 1'b0;
         endcase
      end
   end
endmodule : fifo_flag_calc
`default_nettype wire

// ---- verilog/fifo_flag_if.sv ----
`timescale 1ns/1ps
`default_nettype none
interface fifo_flag_if;
   import rx_fifo_pkg::*;
   logic [CNT_W-1:0]   count [RX_CHANNELS];
   logic [THR_W-1:0]   thrLevel;
   logic [1:0]         flagSourceSelect [RX_CHANNELS];
   logic [RX_CHANNELS-1:0] fifoNonemptyBit;
   logic [RX_CHANNELS-1:0] fifoOverLevelBit;
   logic [RX_CHANNELS-1:0] fifoFullBit;
   logic [RX_CHANNELS-1:0] channelSelectedFlag;

   // Flag calculator sees counts and settings, returns flags
   modport calc (input count, thrLevel, flagSourceSelect,
                 output fifoNonemptyBit, fifoOverLevelBit, fifoFullBit,
                 channelSelectedFlag);
   modport user (output count, thrLevel, flagSourceSelect,
                 input fifoNonemptyBit, fifoOverLevelBit, fifoFullBit,
                 channelSelectedFlag);
endinterface : fifo_flag_if
`default_nettype wire

// ---- verilog/rx_fifo_pkg.sv ----
`default_nettype none
package rx_fifo_pkg;
   // Channel counts and FIFO depth
   localparam int RX_CHANNELS = 8;
   localparam int TX_CHANNELS = 4;
   localparam int FIFO_DEPTH  = 32;
   localparam int CNT_W       = 6;
   localparam int THR_W       = 5;

   // Register byte offsets on the host register port
   localparam logic [15:0] OFS_MUXED_FLAGS = 16'h800C;
   localparam logic [15:0] OFS_RX_CTRL0    = 16'h8010;
   localparam logic [15:0] OFS_RX_CTRL7    = 16'h8017;
   localparam logic [15:0] OFS_LOOPBACK    = 16'h8022;
   localparam logic [15:0] OFS_THR_LEVEL   = 16'h8028;
   localparam logic [15:0] OFS_FULL_FLAGS  = 16'h8029;
   localparam logic [15:0] OFS_OVER_FLAGS  = 16'h802A;
   localparam logic [15:0] OFS_NONEMPTY    = 16'h802B;

   // Reset values
   localparam logic [7:0]       RST_FLAGS     = 8'h00;
   localparam logic [7:0]       RST_RX_CTRL   = 8'h00;
   localparam logic [7:0]       RST_LOOPBACK  = 8'h00;
   localparam logic [THR_W-1:0] RST_THR_LEVEL = 5'h10;
   localparam logic [7:0]       UNMAPPED_READ = 8'h00;

   // Field position of the flag source select in each control register
   localparam int FSEL_LSB = 0;

   // Flag source select encodings
   typedef enum logic [1:0]
   {
      FSEL_NEVER    = 2'h0,
      FSEL_NONEMPTY = 2'h1,
      FSEL_OVER     = 2'h2,
      FSEL_FULL     = 2'h3
   } flag_source_select_t;
endpackage : rx_fifo_pkg
`default_nettype wire

// ---- verilog/rx_fifo_status_and_loopback.sv ----
`timescale 1ns/1ps
`default_nettype none
// How it works
// - Nonempty bit per channel when count nonzero
// - Over-level bit when count exceeds level
// - Full bit when count reaches 32
// - Per-channel flag chosen by select field
// - Level zero means at least one
// - Level all ones equals full
// - Level resets to sixteen
// - Loopback bit feeds receiver from transmitter
// - Transmitter k feeds receivers 2k, 2k+1
// - External input ignored during loopback
// - Transmit mask disables transmit pins
// - Reset empties FIFOs, clears status
// - Select 00 never,01 nonempty,10 over,11 full
// - Write into full FIFO drops oldest
module rx_fifo_status_and_loopback
(
   input  wire logic                               clk_sys,
   input  wire logic                               rst,
   input  wire logic [15:0]                        regAddr,
   input  wire logic                               regWrEn,
   input  wire logic [7:0]                         regWrData,
   input  wire logic                               regRdEn,
   output logic      [7:0]                         regRdData,
   input  wire logic [rx_fifo_pkg::RX_CHANNELS-1:0] msgWrite,
   input  wire logic [rx_fifo_pkg::RX_CHANNELS-1:0] msgRead,
   input  wire logic [rx_fifo_pkg::RX_CHANNELS-1:0] rxPinSerial,
   input  wire logic [rx_fifo_pkg::TX_CHANNELS-1:0] txSerial,
   output logic      [rx_fifo_pkg::RX_CHANNELS-1:0] receiverSerial,
   input  wire logic                               transmitOutputMask,
   output logic      [rx_fifo_pkg::TX_CHANNELS-1:0] txPinOut,
   output logic      [rx_fifo_pkg::TX_CHANNELS-1:0] txPinOe,
   output logic      [rx_fifo_pkg::RX_CHANNELS-1:0] channelSelectedFlag
);
   import rx_fifo_pkg::*;

   localparam logic [CNT_W-1:0] CNT_FULL = CNT_W'(FIFO_DEPTH);

   logic [CNT_W-1:0]       count_r [RX_CHANNELS];
   logic [CNT_W-1:0]       count_nxt [RX_CHANNELS];
   logic [7:0]             rxCtrl_r [RX_CHANNELS];
   logic [7:0]             rxCtrl_nxt [RX_CHANNELS];
   logic [THR_W-1:0]       thrLevel_r;
   logic [THR_W-1:0]       thrLevel_nxt;
   logic [RX_CHANNELS-1:0] loopbackRouteBits_r;
   logic [RX_CHANNELS-1:0] loopbackRouteBits_nxt;
   logic [7:0]             rdData_r;
   logic [7:0]             rdData_nxt;
   logic [RX_CHANNELS-1:0] rxRoute_r;
   logic [RX_CHANNELS-1:0] rxRoute_nxt;
   logic [TX_CHANNELS-1:0] txOut_r;
   logic [TX_CHANNELS-1:0] txOut_nxt;
   logic [TX_CHANNELS-1:0] txOe_r;
   logic [TX_CHANNELS-1:0] txOe_nxt;

   fifo_flag_if flags ();

   fifo_flag_calc u_calc
   (
      .flags (flags.calc)
   );

   // Hand counts and settings to the flag calculator
   always_comb
   begin
      flags.thrLevel = thrLevel_r;
      for (int ch = 0; ch < RX_CHANNELS; ch++)
      begin
         flags.count[ch]            = count_r[ch];
         flags.flagSourceSelect[ch] = rxCtrl_r[ch][FSEL_LSB +: 2];
      end
   end

   assign channelSelectedFlag = flags.channelSelectedFlag;
   assign regRdData           = rdData_r;
   assign receiverSerial      = rxRoute_r;
   assign txPinOut            = txOut_r;
   assign txPinOe             = txOe_r;

   // Occupancy counts: storage lives elsewhere, only depth is tracked
   always_comb
   begin
      for (int ch = 0; ch < RX_CHANNELS; ch++)
      begin
         count_nxt[ch] = count_r[ch];
         if (msgWrite[ch] && !msgRead[ch])
         begin
            // full write drops oldest, count holds
            if (count_r[ch] != CNT_FULL)
               count_nxt[ch] = count_r[ch] + 6'h01;
         end
         else if (msgRead[ch] && !msgWrite[ch])
         begin
            if (count_r[ch] != '0)
               count_nxt[ch] = count_r[ch] - 6'h01;
         end
         else if (msgRead[ch] && msgWrite[ch] && count_r[ch] == '0)
            count_nxt[ch] = 6'h01; // Nothing to pop, the write lands
      end
   end

   // Register writes; status offsets are derived and ignore writes
   always_comb
   begin
      thrLevel_nxt          = thrLevel_r;
      loopbackRouteBits_nxt = loopbackRouteBits_r;
      for (int ch = 0; ch < RX_CHANNELS; ch++)
         rxCtrl_nxt[ch] = rxCtrl_r[ch];
      if (regWrEn)
      begin
         if (regAddr == OFS_THR_LEVEL)
            thrLevel_nxt = regWrData[THR_W-1:0];
         // routing takes the written value next cycle
         if (regAddr == OFS_LOOPBACK)
            loopbackRouteBits_nxt = regWrData;
         if (regAddr >= OFS_RX_CTRL0 && regAddr <= OFS_RX_CTRL7)
            rxCtrl_nxt[regAddr[2:0]] = regWrData;
      end
   end

   // Read mux, captured on the read strobe; unmapped reads return zero
   always_comb
   begin
      rdData_nxt = rdData_r;
      if (regRdEn)
      begin
         rdData_nxt = UNMAPPED_READ;
         case (regAddr)
            OFS_MUXED_FLAGS: rdData_nxt = flags.channelSelectedFlag;
            OFS_FULL_FLAGS:  rdData_nxt = flags.fifoFullBit;
            OFS_OVER_FLAGS:  rdData_nxt = flags.fifoOverLevelBit;
            OFS_NONEMPTY:    rdData_nxt = flags.fifoNonemptyBit;
            OFS_LOOPBACK:    rdData_nxt = loopbackRouteBits_r;
            OFS_THR_LEVEL:   rdData_nxt = {3'h0, thrLevel_r};
            default:
            begin
               if (regAddr >= OFS_RX_CTRL0 && regAddr <= OFS_RX_CTRL7)
                  rdData_nxt = rxCtrl_r[regAddr[2:0]];
            end
         endcase
      end
   end

   // Receiver input routing and transmit pin gating
   always_comb
   begin
      for (int ch = 0; ch < RX_CHANNELS; ch++)
      begin
         // pin data never reaches a looped receiver
         rxRoute_nxt[ch] = loopbackRouteBits_r[ch] ? txSerial[ch / 2]
                                                  : rxPinSerial[ch];
      end
      // mask parks pins low and releases them
      txOut_nxt = transmitOutputMask ? '0 : txSerial;
      txOe_nxt  = transmitOutputMask ? '0 : '1;
   end

   // Single register stage for all state
   always_ff @(posedge clk_sys)
   begin
      if (rst)
      begin
         thrLevel_r          <= RST_THR_LEVEL;
         loopbackRouteBits_r <= RST_LOOPBACK;
         rdData_r            <= RST_FLAGS;
         rxRoute_r           <= '0;
         txOut_r             <= '0;
         txOe_r              <= '0;
         for (int ch = 0; ch < RX_CHANNELS; ch++)
         begin
            count_r[ch]  <= '0;
            rxCtrl_r[ch] <= RST_RX_CTRL;
         end
      end
      else
      begin
         thrLevel_r          <= thrLevel_nxt;
         loopbackRouteBits_r <= loopbackRouteBits_nxt;
         rdData_r            <= rdData_nxt;
         rxRoute_r           <= rxRoute_nxt;
         txOut_r             <= txOut_nxt;
         txOe_r              <= txOe_nxt;
         for (int ch = 0; ch < RX_CHANNELS; ch++)
         begin
            count_r[ch]  <= count_nxt[ch];
            rxCtrl_r[ch] <= rxCtrl_nxt[ch];
         end
      end
   end

   // Checks on channel 0, the channel 1 select, all-channel flags, the transmit mask and the routing of receiver 3
   default clocking cb @(posedge clk_sys);
   endclocking
   default disable iff (rst);

   a_write_sets_nonempty: assert property (
      msgWrite[0] && !msgRead[0] |=> flags.fifoNonemptyBit[0])
      else $error("write did not set nonempty");
   // A level write in the same cycle would move the goal post, so skip it
   a_over_follows_count: assert property (
      msgWrite[0] && !msgRead[0] && count_r[0] == {1'b0, thrLevel_r}
      && !(regWrEn && regAddr == OFS_THR_LEVEL)
      |=> flags.fifoOverLevelBit[0])
      else $error("over-level not set above level");
   a_full_holds_full: assert property (
      flags.fifoFullBit[0] && msgWrite[0] && !msgRead[0]
      |=> flags.fifoFullBit[0] && count_r[0] == CNT_FULL)
      else $error("full write lost full state");
   a_full_level_same: assert property (
      thrLevel_r == 5'h1F |-> flags.fifoOverLevelBit == flags.fifoFullBit)
      else $error("all-ones level differs from full");
   a_select_picks_source: assert property (
      rxCtrl_r[0][1:0] == 2'h3
      |-> channelSelectedFlag[0] == flags.fifoFullBit[0])
      else $error("muxed flag wrong source");
   a_never_select_low: assert property (
      rxCtrl_r[1][1:0] == 2'h0 |-> !channelSelectedFlag[1])
      else $error("never select still raised flag");
   a_reset_clears_all: assert property (
      disable iff (1'b0) rst |=> flags.fifoNonemptyBit == '0
      && flags.fifoFullBit == '0 && thrLevel_r == RST_THR_LEVEL)
      else $error("reset left status or level");
   a_read_drops_over: assert property (
      flags.fifoOverLevelBit[0] && msgRead[0] && !msgWrite[0]
      && count_r[0] == {1'b0, thrLevel_r} + 6'h01
      && !(regWrEn && regAddr == OFS_THR_LEVEL)
      |=> !flags.fifoOverLevelBit[0])
      else $error("over-level did not drop on read");
   a_loop_write_next: assert property (
      regWrEn && regAddr == OFS_LOOPBACK
      |=> loopbackRouteBits_r == $past(regWrData))
      else $error("loopback bits not taken next cycle");
   a_loop_routes_tx: assert property (
      loopbackRouteBits_r[3] |=> receiverSerial[3] == $past(txSerial[1]))
      else $error("receiver 3 not fed by transmitter 1");
   a_pin_routes_rx: assert property (
      !loopbackRouteBits_r[3] |=> receiverSerial[3] == $past(rxPinSerial[3]))
      else $error("receiver 3 not fed by its pin");
   a_mask_gates_pins: assert property (
      transmitOutputMask |=> txPinOe == '0 && txPinOut == '0)
      else $error("masked transmit pins still driven");

   c_fifo_fills:   cover property (msgWrite[0] ##1 flags.fifoFullBit[0]);
   c_over_crosses: cover property ($rose(flags.fifoOverLevelBit[0]));
   c_loop_masked:  cover property (loopbackRouteBits_r[0]
                                   && transmitOutputMask);
endmodule : rx_fifo_status_and_loopback
`default_nettype wire
